//--- logic/bus_cmd_pkg.sv
// Constants and carrier types for the bus command decoder.
// Assumes one 40 MHz clock and no register bus.
package bus_cmd_pkg;

  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;

  // Multiline command codes
  localparam logic [7:0] CMD_GO_LOCAL = 8'h01;
  localparam logic [7:0] CMD_SEL_CLEAR = 8'h04;
  localparam logic [7:0] CMD_GROUP_TRIG = 8'h08;
  localparam logic [7:0] CMD_LOCKOUT = 8'h11;
  localparam logic [7:0] CMD_DEV_CLEAR = 8'h14;
  localparam logic [7:0] CMD_POLL_ON = 8'h18;
  localparam logic [7:0] CMD_POLL_OFF = 8'h19;
  localparam logic [7:0] CMD_UNLISTEN = 8'h3f;
  localparam logic [7:0] CMD_UNTALK = 8'h5f;

  // Address groups: bits 6:5 select the group
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECONDARY = 2'h3;
  localparam logic [1:0] GRP_COMMAND = 2'h0;
  localparam logic [4:0] ADDR_INVALID = 5'h1f;

  // Bus lines as seen after inversion: 1 means true
  typedef struct packed {
    logic atn;
    logic ifc;
    logic ren;
    logic eoi;
    logic dav;
    logic [7:0] dio;
  } bus_lines_type;

  // One byte for the instrument
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } data_word_type;

  localparam int WORD_W = $bits(data_word_type);

  typedef enum logic [1:0] {
    HS_READY,
    HS_LATCH,
    HS_WAIT_DROP
  } hs_state_type;

endpackage

//--- logic/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- logic/bus_cmd_decoder.sv
// Device-side decoder for bus commands, addresses and instrument data.
// Assumes raw active-low bus lines from pins; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - ATN true: byte is command or address
// - ATN false: byte goes to instrument; queued only while listening, else dropped
// - REN true enters remote, optional lockout
// - EOI marks the last byte of transfer
// - IFC clears talker and listener state
// - Service request held until serviced; a device clear also drops it
// - Universal commands act without addressing
// - Code 11 locks front panel
// - Code 14 restores power-up defaults
// - Code 18 poll on, 19 poll off
// - Addressed commands need own listen address; group trigger also acts unaddressed when trig_unaddressed_i is set
// - Code 04 clears only when listening
// - Code 01 while listening leaves remote
// - Group trigger starts configured trigger action
// - Listen address is 20 OR primary
// - Talk address is 40 OR primary
// - Secondary codes 60 to 7F ignored
// - Code 3F sends device to listen idle
// - Code 5F sends device to talk idle
// - All bus lines are low true
// - Primary address 0 to 30 only
// - Hold not-accepted until byte is latched
module bus_cmd_decoder (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Bus lines, active low from the pins
  input wire logic atn_n_i,
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  input wire logic eoi_n_i,
  input wire logic dav_n_i,
  input wire logic [7:0] dio_n_i,
  // Acceptor handshake, open drain
  output logic nrfd_n_o,
  output logic nrfd_oe_o,
  output logic ndac_n_o,
  output logic ndac_oe_o,
  // Service request, open drain
  output logic srq_n_o,
  output logic srq_oe_o,
  // Configuration
  input wire logic [4:0] primary_addr_i,
  input wire logic ren_lockout_i,
  input wire logic gtl_unlock_i,
  input wire logic trig_unaddressed_i,
  // Instrument side
  input wire logic service_req_i,
  input wire logic service_done_i,
  output logic listen_o,
  output logic talk_o,
  output logic remote_o,
  output logic lockout_o,
  output logic poll_mode_o,
  output logic clear_o,
  output logic trigger_o,
  output logic [7:0] data_o,
  output logic data_last_o,
  output logic data_valid_o,
  input wire logic data_ready_i
);
  import bus_cmd_pkg::*;

  // ==========================================================
  // Pin synchronisers: three stages, a change counts once
  // stages two and three agree.
  // ==========================================================
  bus_lines_type raw_lines;
  bus_lines_type s1_reg, s2_reg, s3_reg, lines_reg, lines_next;

  // Inverting here keeps everything downstream positive-true
  assign raw_lines = bus_lines_type'({~atn_n_i, ~ifc_n_i, ~ren_n_i,
                                      ~eoi_n_i, ~dav_n_i, ~dio_n_i});

  assign lines_next = (s2_reg == s3_reg) ? s3_reg : lines_reg;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      lines_reg <= '0;
    end else begin
      s1_reg <= raw_lines;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lines_reg <= lines_next;
    end
  end

  // ==========================================================
  // Acceptor handshake
  // ==========================================================
  hs_state_type hs_reg, hs_next;
  logic fifo_in_ready;
  wire take_byte = (hs_reg == HS_LATCH);

  always_comb begin
    hs_next = hs_reg;
    case (hs_reg)
      HS_READY: begin
        if (lines_reg.dav) begin
          hs_next = HS_LATCH;
        end
      end
      HS_LATCH: begin
        hs_next = HS_WAIT_DROP;
      end
      HS_WAIT_DROP: begin
        if (!lines_reg.dav) begin
          hs_next = HS_READY;
        end
      end
      default: begin
        hs_next = HS_READY;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hs_reg <= HS_READY;
    end else begin
      hs_reg <= hs_next;
    end
  end

  // Data bytes need FIFO room, so a full FIFO stalls the talker.
  // Command bytes never wait: ATN traffic must not hang on the instrument.
  wire room_ok = lines_reg.atn || fifo_in_ready;
  wire rfd_true = (hs_reg == HS_READY) && room_ok && !lines_reg.dav;
  wire dac_true = (hs_reg == HS_WAIT_DROP);

  // Open-drain: drive low for true, release otherwise
  assign nrfd_n_o = 1'b0;
  assign nrfd_oe_o = !rfd_true;
  assign ndac_n_o = 1'b0;
  assign ndac_oe_o = !dac_true;

  // ==========================================================
  // Command decode; ATN splits command bytes from data here, IFC and REN act in the interface state
  // ==========================================================
  wire [7:0] byte_in = lines_reg.dio;
  wire [1:0] grp = byte_in[6:5];
  wire is_cmd = take_byte && lines_reg.atn;
  wire is_data = take_byte && !lines_reg.atn;
  wire addr_ok = (primary_addr_i != ADDR_INVALID);
  wire [7:0] my_listen = {3'b001, primary_addr_i};
  wire [7:0] my_talk = {3'b010, primary_addr_i};
  wire cmd_unl = is_cmd && (byte_in[6:0] == CMD_UNLISTEN[6:0]);
  wire cmd_unt = is_cmd && (byte_in[6:0] == CMD_UNTALK[6:0]);
  // Top-of-range codes win over address match
  wire cmd_mla = is_cmd && !cmd_unl && addr_ok && (grp == GRP_LISTEN)
                 && (byte_in[6:0] == my_listen[6:0]);
  wire cmd_mta = is_cmd && !cmd_unt && addr_ok && (grp == GRP_TALK)
                 && (byte_in[6:0] == my_talk[6:0]);
  // Another talk address takes the talker away
  wire cmd_ota = is_cmd && (grp == GRP_TALK) && !cmd_mta && !cmd_unt;
  wire is_pcg = is_cmd && (grp == GRP_COMMAND);
  wire cmd_secondary = is_cmd && (grp == GRP_SECONDARY);
  wire cmd_llo = is_pcg && (byte_in[6:0] == CMD_LOCKOUT[6:0]);
  wire cmd_dcl = is_pcg && (byte_in[6:0] == CMD_DEV_CLEAR[6:0]);
  wire cmd_spe = is_pcg && (byte_in[6:0] == CMD_POLL_ON[6:0]);
  wire cmd_spd = is_pcg && (byte_in[6:0] == CMD_POLL_OFF[6:0]);
  logic listen_reg, talk_reg;
  wire cmd_sdc = is_pcg && listen_reg
                 && (byte_in[6:0] == CMD_SEL_CLEAR[6:0]);
  wire cmd_gtl = is_pcg && listen_reg
                 && (byte_in[6:0] == CMD_GO_LOCAL[6:0]);
  wire cmd_get = is_pcg && (listen_reg || trig_unaddressed_i)
                 && (byte_in[6:0] == CMD_GROUP_TRIG[6:0]);
  wire dev_clear = cmd_dcl || cmd_sdc;

  // ==========================================================
  // Interface state
  // ==========================================================
  logic remote_reg, lockout_reg, poll_reg, clear_reg, trigger_reg;
  logic srq_reg;
  logic ren_prev_reg;
  wire ren_drop = !lines_reg.ren;
  // Remote is entered on the REN edge or on own listen address, so a
  // go-to-local stays in force while REN is held
  wire ren_rise = lines_reg.ren && !ren_prev_reg;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ren_prev_reg <= 1'b0;
    end else begin
      ren_prev_reg <= lines_reg.ren;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      listen_reg <= 1'b0;
      talk_reg <= 1'b0;
    end else if (lines_reg.ifc) begin
      listen_reg <= 1'b0;
      talk_reg <= 1'b0;
    end else begin
      // Each state changes only on its own codes
      if (cmd_mla) begin
        listen_reg <= 1'b1;
      end else if (cmd_unl) begin
        listen_reg <= 1'b0;
      end
      if (cmd_mta) begin
        talk_reg <= 1'b1;
      end else if (cmd_unt || cmd_ota) begin
        talk_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      remote_reg <= 1'b0;
      lockout_reg <= 1'b0;
    end else if (ren_drop) begin
      // Releasing REN always returns to local and clears lockout
      remote_reg <= 1'b0;
      lockout_reg <= 1'b0;
    end else begin
      if (cmd_gtl) begin
        remote_reg <= 1'b0;
      end else if (ren_rise || cmd_mla) begin
        remote_reg <= 1'b1;
      end
      if (cmd_llo || ren_lockout_i) begin
        lockout_reg <= 1'b1;
      end else if (cmd_gtl && gtl_unlock_i) begin
        lockout_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      poll_reg <= 1'b0;
      clear_reg <= 1'b0;
      trigger_reg <= 1'b0;
    end else begin
      clear_reg <= dev_clear;
      trigger_reg <= cmd_get;
      if (lines_reg.ifc || cmd_spd) begin
        poll_reg <= 1'b0;
      end else if (cmd_spe) begin
        poll_reg <= 1'b1;
      end
    end
  end

  // Request held until the instrument reports it serviced or a device clear;
  // a new request in the same cycle as the clear wins.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      srq_reg <= 1'b0;
    end else if (service_req_i) begin
      srq_reg <= 1'b1;
    end else if (service_done_i || dev_clear) begin
      srq_reg <= 1'b0;
    end
  end

  assign srq_n_o = 1'b0;
  assign srq_oe_o = srq_reg;

  assign listen_o = listen_reg;
  assign talk_o = talk_reg;
  assign remote_o = remote_reg;
  assign lockout_o = lockout_reg;
  assign poll_mode_o = poll_reg;
  assign clear_o = clear_reg;
  assign trigger_o = trigger_reg;

  // ==========================================================
  // Instrument data path; only listened data is queued
  // ==========================================================
  data_word_type in_word;
  logic [WORD_W-1:0] out_word_raw;
  data_word_type out_word;
  wire push_data = is_data && listen_reg;

  assign in_word = '{last: lines_reg.eoi, data: byte_in};
  assign out_word = data_word_type'(out_word_raw);

  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) data_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(dev_clear || lines_reg.ifc),
    .in_valid_i(push_data),
    .in_ready_o(fifo_in_ready),
    .in_data_i(in_word),
    .out_valid_o(data_valid_o),
    .out_ready_i(data_ready_i),
    .out_data_o(out_word_raw)
  );

  assign data_o = out_word.data;
  assign data_last_o = out_word.last;

  // Secondary bytes are handshaken and dropped
  wire unused_ok = cmd_secondary;
endmodule
`default_nettype wire

//--- verif/bus_cmd_asserts.sv
// Concurrent checks on the bus command decoder's ports.
// Assumes one clock and the active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module bus_cmd_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Bus and configuration
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  input wire logic dav_n_i,
  input wire logic [4:0] primary_addr_i,
  input wire logic ren_lockout_i,
  input wire logic service_req_i,
  // Device outputs
  input wire logic nrfd_oe_o,
  input wire logic ndac_oe_o,
  input wire logic srq_oe_o,
  input wire logic listen_o,
  input wire logic talk_o,
  input wire logic remote_o,
  input wire logic lockout_o,
  input wire logic clear_o,
  input wire logic trigger_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================
  // Pin lines pass a sync pipeline, so levels get 8 cycles to act
  chk_ifc_idle: assert property (
    !ifc_n_i [*8] |-> !listen_o && !talk_o) else $error("IFC kept state");
  chk_ren_local: assert property (
    ren_n_i [*8] |-> !remote_o && !lockout_o) else $error("not local");
  chk_ren_lock: assert property (
    (!ren_n_i && ren_lockout_i) [*8] |-> lockout_o) else $error("no lock");
  chk_srq_set: assert property (
    service_req_i |=> srq_oe_o) else $error("SRQ not raised");
  chk_nrfd_latch: assert property (
    $fell(ndac_oe_o) |-> nrfd_oe_o) else $error("ready while latching");
  chk_ndac_held: assert property (
    !ndac_oe_o && !dav_n_i |=> !ndac_oe_o) else $error("NDAC dropped");
  chk_clear_pulse: assert property (
    clear_o |-> !ndac_oe_o ##1 !clear_o) else $error("bad clear pulse");
  chk_trig_pulse: assert property (
    trigger_o |-> !ndac_oe_o ##1 !trigger_o) else $error("bad trigger");
  chk_listen_cause: assert property (
    $rose(listen_o) |-> !ndac_oe_o) else $error("listen without byte");
  chk_addr_invalid: assert property (
    primary_addr_i == 5'h1f && !listen_o |=> !listen_o)
    else $error("address 31 matched");
endmodule
bind bus_cmd_decoder bus_cmd_asserts u_chk (.clk_i, .sys_rst_i, .ifc_n_i,
  .ren_n_i, .dav_n_i, .primary_addr_i, .ren_lockout_i, .service_req_i,
  .nrfd_oe_o, .ndac_oe_o, .srq_oe_o, .listen_o, .talk_o, .remote_o,
  .lockout_o, .clear_o, .trigger_o);
`default_nettype wire

//--- verif/bus_ctl_model.sv
// Behavioural bus controller sourcing bytes over the three-wire handshake.
// Assumes the device under test is the only acceptor on the bus.
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model (
  // Clock and bench requests
  input wire logic clk_i,
  input wire logic ren_i,
  input wire logic ifc_i,
  // Acceptor lines
  input wire logic nrfd_oe_i,
  input wire logic ndac_oe_i,
  // Bus lines, low true
  output logic atn_n_o,
  output logic ifc_n_o,
  output logic ren_n_o,
  output logic eoi_n_o,
  output logic dav_n_o,
  output logic [7:0] dio_n_o
);
  assign ren_n_o = ~ren_i;
  assign ifc_n_o = ~ifc_i;
  initial begin
    atn_n_o = 1'b1;
    eoi_n_o = 1'b1;
    dav_n_o = 1'b1;
    dio_n_o = 8'hff;
  end
  // ==========================================
  // Sampling on the falling edge keeps clear of the device's updates
  task automatic wt(input bit k);
    int n;
    n = 0;
    @(negedge clk_i);
    while ((k ? ndac_oe_i !== 1'b0
              : (nrfd_oe_i !== 1'b0 || ndac_oe_i !== 1'b1)) && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 400) begin
      bus_cmd_decoder_tb.err_total++;
      bus_cmd_decoder_tb.conclude();
    end
  endtask
  task automatic send(input logic a, input logic e, input logic [7:0] b);
    wt(1'b0);
    @(posedge clk_i);
    atn_n_o <= ~a;
    eoi_n_o <= ~e;
    dio_n_o <= ~b;
    @(posedge clk_i);
    dav_n_o <= 1'b0;
    wt(1'b1);
    @(posedge clk_i);
    dav_n_o <= 1'b1;
    eoi_n_o <= 1'b1;
    // Released lines float up to the terminators
    dio_n_o <= 8'hff;
  endtask
endmodule
`default_nettype wire

//--- verif/bus_cmd_decoder_tb.sv
// Self-checking bench for the bus command decoder.
// Assumes the controller model drives every bus line but NRFD, NDAC and SRQ.
`timescale 1ns/1ps
`default_nettype none
module bus_cmd_decoder_tb;
  import bus_cmd_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ren = 1'b0;
  logic ifc = 1'b0;
  logic [4:0] primary_addr_i = 5'h08;
  logic ren_lockout_i = 1'b0;
  logic gtl_unlock_i = 1'b0;
  logic trig_unaddressed_i = 1'b0;
  logic service_req_i = 1'b0;
  logic service_done_i = 1'b0;
  logic data_ready_i = 1'b0;
  wire logic atn_n_i, ifc_n_i, ren_n_i, eoi_n_i, dav_n_i;
  wire logic [7:0] dio_n_i;
  logic nrfd_oe_o, ndac_oe_o, srq_oe_o, listen_o, talk_o, remote_o;
  logic lockout_o, poll_mode_o, clear_o, trigger_o, data_last_o;
  logic data_valid_o, nrfd_n_o, ndac_n_o, srq_n_o;
  logic [7:0] data_o, lag, tlk;
  int err_total = 0;
  int tests_run = 0;
  int clr_cnt = 0;
  int trg_cnt = 0;
  assign lag = 8'h20 | {3'b000, primary_addr_i};
  assign tlk = 8'h40 | {3'b000, primary_addr_i};
  always #12.5 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    clr_cnt += int'(clear_o === 1'b1);
    trg_cnt += int'(trigger_o === 1'b1);
  end
  bus_ctl_model u_ctl (.clk_i, .ren_i(ren), .ifc_i(ifc),
    .nrfd_oe_i(nrfd_oe_o), .ndac_oe_i(ndac_oe_o), .atn_n_o(atn_n_i),
    .ifc_n_o(ifc_n_i), .ren_n_o(ren_n_i), .eoi_n_o(eoi_n_i),
    .dav_n_o(dav_n_i), .dio_n_o(dio_n_i));
  bus_cmd_decoder u_dut (.clk_i, .sys_rst_i, .atn_n_i, .ifc_n_i, .ren_n_i,
    .eoi_n_i, .dav_n_i, .dio_n_i, .nrfd_n_o, .nrfd_oe_o, .ndac_n_o,
    .ndac_oe_o, .srq_n_o, .srq_oe_o, .primary_addr_i, .ren_lockout_i,
    .gtl_unlock_i, .trig_unaddressed_i, .service_req_i,
    .service_done_i, .listen_o, .talk_o, .remote_o, .lockout_o,
    .poll_mode_o, .clear_o, .trigger_o, .data_o, .data_last_o,
    .data_valid_o, .data_ready_i);
  // ==========================================
  // Tasks
  task automatic conclude;
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic tx(input logic a, input logic [7:0] b);
    u_ctl.send(a, 1'b0, b);
  endtask
  task automatic rd(input logic [8:0] exp);
    int n;
    n = 0;
    @(negedge clk_i);
    while (data_valid_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 200) begin
      err_total++;
      conclude();
    end
    chk({data_last_o, data_o}, exp);
    @(posedge clk_i);
    data_ready_i <= 1'b1;
    @(posedge clk_i);
    data_ready_i <= 1'b0;
  endtask
  // ==========================================
  // Sequence
  initial begin
    cyc(16);
    sys_rst_i <= 1'b0;
    cyc(8);
    chk({nrfd_n_o, ndac_n_o, srq_n_o}, 3'b000);
    tx(1'b1, CMD_UNLISTEN);
    tx(1'b1, lag);
    chk(listen_o, 1'b1);
    tx(1'b1, tlk);
    chk({listen_o, talk_o}, 2'b11);
    tx(1'b1, CMD_UNLISTEN);
    chk({listen_o, talk_o}, 2'b01);
    tx(1'b1, CMD_UNTALK);
    chk(talk_o, 1'b0);
    tx(1'b1, CMD_SEL_CLEAR);
    chk(9'(clr_cnt), 9'h000);
    tx(1'b1, CMD_GROUP_TRIG);
    chk(9'(trg_cnt), 9'h000);
    trig_unaddressed_i <= 1'b1;
    tx(1'b1, CMD_GROUP_TRIG);
    chk(9'(trg_cnt), 9'h001);
    trig_unaddressed_i <= 1'b0;
    tx(1'b1, CMD_DEV_CLEAR);
    chk(9'(clr_cnt), 9'h001);
    tx(1'b1, CMD_UNLISTEN);
    tx(1'b1, lag);
    tx(1'b1, CMD_SEL_CLEAR);
    chk(9'(clr_cnt), 9'h002);
    tx(1'b1, CMD_GROUP_TRIG);
    chk(9'(trg_cnt), 9'h002);
    tx(1'b1, 8'h68);
    chk({listen_o, talk_o}, 2'b10);
    ren <= 1'b1;
    cyc(8);
    chk(remote_o, 1'b1);
    tx(1'b1, CMD_LOCKOUT);
    chk(lockout_o, 1'b1);
    tx(1'b1, CMD_POLL_ON);
    chk(poll_mode_o, 1'b1);
    tx(1'b1, CMD_POLL_OFF);
    chk(poll_mode_o, 1'b0);
    gtl_unlock_i <= 1'b1;
    tx(1'b1, CMD_GO_LOCAL);
    chk({remote_o, lockout_o}, 2'b00);
    ren_lockout_i <= 1'b1;
    cyc(8);
    chk(lockout_o, 1'b1);
    ren <= 1'b0;
    ren_lockout_i <= 1'b0;
    cyc(8);
    chk({remote_o, lockout_o}, 2'b00);
    tx(1'b0, tlk);
    u_ctl.send(1'b0, 1'b1, 8'h52);
    chk(talk_o, 1'b0);
    rd({1'b0, tlk});
    rd(9'h152);
    for (int i = 0; i < FIFO_DEPTH; i++) tx(1'b0, 8'(i));
    cyc(12);
    chk(nrfd_oe_o, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) rd({1'b0, 8'(i)});
    cyc(2);
    chk(data_valid_o, 1'b0);
    service_req_i <= 1'b1;
    cyc(1);
    service_req_i <= 1'b0;
    cyc(6);
    chk(srq_oe_o, 1'b1);
    service_done_i <= 1'b1;
    cyc(1);
    service_done_i <= 1'b0;
    cyc(2);
    chk(srq_oe_o, 1'b0);
    tx(1'b1, tlk);
    tx(1'b1, 8'h4a);
    chk(talk_o, 1'b0);
    tx(1'b1, tlk);
    tx(1'b1, CMD_POLL_ON);
    ifc <= 1'b1;
    primary_addr_i <= 5'h1f;
    cyc(10);
    ifc <= 1'b0;
    chk({listen_o, talk_o, poll_mode_o}, 3'b000);
    cyc(8);
    conclude();
  end
endmodule
`default_nettype wire
